/* design/ovf_regs.svh */
// Register offsets, field positions, reset values for the over-voltage block
`ifndef OVF_REGS_SVH
`define OVF_REGS_SVH

// ----------------------------------------------------------------------
// Command codes of the two registers
// ----------------------------------------------------------------------
`define OVF_THR_OFS 8'h55
`define OVF_RSP_OFS 8'h56

// ----------------------------------------------------------------------
// Reaction register fields
// ----------------------------------------------------------------------
`define RSP_MODE_HI 7
`define RSP_MODE_LO 6
`define RSP_RETRY_HI 5
`define RSP_RETRY_LO 3
`define RSP_MULT_HI 2
`define RSP_MULT_LO 0

// Response mode codes
`define MODE_IGNORE 2'h0
`define MODE_CONTINUE 2'h1
`define MODE_RETRY 2'h2
`define MODE_LATCH 2'h3

// Retry setting codes
`define RETRY_NONE 3'h0
`define RETRY_ENDLESS 3'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define THR_RST 16'h7bff
`define RSP_RST 8'hc0
`define RD_UNMAPPED 16'h0000

`endif

/* design/ovf_pkg.sv */
// Types shared by the over-voltage fault responder and its delay timer
package ovf_pkg;

  // --------------------------------------------------------------------
  // Fault sequencer states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_RUN = 5'h01,
    ST_HOLD = 5'h02,
    ST_WAIT = 5'h04,
    ST_TRY = 5'h08,
    ST_LATCH = 5'h10
  } ovf_state_e;

  // --------------------------------------------------------------------
  // Sequencer state
  // --------------------------------------------------------------------
  typedef struct packed
  {
    ovf_state_e state;
    logic [2:0] left;
    logic on_prev;
    logic flag;
    logic out_en;
    logic [15:0] thr;
    logic [7:0] rsp;
    logic [15:0] rd_data;
    logic rd_ack;
  } ctl_s;

  // --------------------------------------------------------------------
  // Delay timer state
  // --------------------------------------------------------------------
  typedef struct packed
  {
    logic busy;
    logic [15:0] ulen;
    logic [15:0] ucnt;
    logic [7:0] mcnt;
    logic expired;
    logic [23:0] chk;
    logic [23:0] tgt;
  } tmr_s;

endpackage

/* design/dly_if.sv */
// Link between the fault sequencer and its delay timer
interface dly_if;
  logic load;           // Start a new delay
  logic [7:0] mult;     // Number of delay units
  logic [15:0] unit;    // Clock cycles per delay unit
  logic expired;        // One-cycle pulse at end of delay

  modport ctrl (output load, output mult, output unit, input expired);
  modport tmr (input load, input mult, input unit, output expired);
endinterface

/* design/ovf_delay_timer.sv */
// Delay timer: counts a number of delay units of programmable length
module ovf_delay_timer
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control link
  dly_if.tmr dl
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam ovf_pkg::tmr_s TMR_RST = '{default: '0};
  ovf_pkg::tmr_s q_ff;   // Registered state
  ovf_pkg::tmr_s nxt_q;  // Next state

  assign dl.expired = q_ff.expired;

  // Unit length of zero is treated as one cycle, so a delay always ends
  function automatic logic [15:0] unit_len(input logic [15:0] u);
    return (u == 16'h0000) ? 16'h0001 : u;
  endfunction

  // Next-state logic; a load always restarts, even mid-count
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.expired = 1'b0;
    nxt_q.chk = q_ff.chk + 24'h000001;
    if (dl.load)
    begin
      nxt_q.busy = 1'b1;
      nxt_q.ulen = unit_len(dl.unit);
      nxt_q.ucnt = 16'h0000;
      nxt_q.mcnt = dl.mult - 8'h01;
      nxt_q.chk = 24'h000000;
      nxt_q.tgt = 24'(dl.mult) * 24'(unit_len(dl.unit));
    end
    else if (q_ff.busy)
    begin
      if (q_ff.ucnt == q_ff.ulen - 16'h0001)
      begin
        // One delay unit complete
        nxt_q.ucnt = 16'h0000;
        if (q_ff.mcnt == 8'h00)
        begin
          nxt_q.busy = 1'b0;
          nxt_q.expired = 1'b1;
        end
        else
        begin
          nxt_q.mcnt = q_ff.mcnt - 8'h01;
        end
      end
      else
      begin
        nxt_q.ucnt = q_ff.ucnt + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      q_ff <= TMR_RST;
    else
      q_ff <= nxt_q;
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_timer_span: assert property (
    q_ff.expired |-> q_ff.chk == q_ff.tgt)
    else $error("delay length differs from multiple times unit");

endmodule

/* design/ovf_fault_responder.sv */
// Input over-voltage fault responder: limit, reaction and retry sequencing
`include "ovf_regs.svh"

module ovf_fault_responder
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register command port
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rd_data_ff,
  output logic rd_ack_ff,
  // Fault clearing
  input wire logic clear_faults,
  input wire logic status_clear,
  // Converter side
  input wire logic [15:0] vin_meas,
  input wire logic on_cmd,
  input wire logic other_fault,
  input wire logic [15:0] delay_unit,
  output logic out_enable_ff,
  output logic ov_fault_flag_ff
);

  // --------------------------------------------------------------------
  // Linear format helpers
  // --------------------------------------------------------------------
  // Scale exponent/mantissa to fixed point with 16 fraction bits
  function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
    logic signed [47:0] m;
    logic [4:0] sh;
    m = 48'(signed'(v[10:0]));
    sh = {~v[15], v[14:11]};
    return m <<< sh;
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  localparam ovf_pkg::ctl_s CTL_RST = '{
    state: ovf_pkg::ST_RUN,
    left: 3'h0,
    on_prev: 1'b0,
    flag: 1'b0,
    out_en: 1'b0,
    thr: `THR_RST,
    rsp: `RSP_RST,
    rd_data: `RD_UNMAPPED,
    rd_ack: 1'b0
  };

  ovf_pkg::ctl_s q_ff;       // Registered state
  ovf_pkg::ctl_s nxt_q;      // Next state
  dly_if dl ();              // Link to the delay timer
  logic fault;               // Input above limit this cycle
  logic clr_evt;             // Any clearing event
  logic stop_retry;          // Output commanded off or other shutdown
  logic [1:0] mode;          // Response field
  logic [2:0] retry;         // Retry field
  logic load;                // Start a delay

  assign mode = q_ff.rsp[`RSP_MODE_HI:`RSP_MODE_LO];
  assign retry = q_ff.rsp[`RSP_RETRY_HI:`RSP_RETRY_LO];

  // Over-voltage when the measured input exceeds the limit
  assign fault = lin_to_fix(vin_meas) > lin_to_fix(q_ff.thr);

  // Off-then-on shows as a rising edge of the on command
  assign clr_evt = status_clear | clear_faults |
    (on_cmd & ~q_ff.on_prev);
  assign stop_retry = ~on_cmd | other_fault;

  // --------------------------------------------------------------------
  // Delay timer
  // --------------------------------------------------------------------
  // Unit length is an input fed from the separate unit setting
  assign dl.load = load;
  assign dl.mult = 8'h01 << q_ff.rsp[`RSP_MULT_HI:`RSP_MULT_LO];
  assign dl.unit = delay_unit;

  ovf_delay_timer u_timer
  (
    .clk(clk),
    .resetn(resetn),
    .dl(dl.tmr)
  );

  // --------------------------------------------------------------------
  // Sequencer and registers
  // --------------------------------------------------------------------
  // One process computes the whole next state
  always_comb
  begin
    nxt_q = q_ff;
    load = 1'b0;
    nxt_q.on_prev = on_cmd;
    nxt_q.rd_ack = 1'b0;

    // Sticky flag: a new detection wins over a clear in the same cycle
    nxt_q.flag = fault | (q_ff.flag & ~clr_evt);

    // Register writes
    if (cmd_wr)
    begin
      if (cmd_code == `OVF_THR_OFS)
        nxt_q.thr = cmd_wdata;
      else if (cmd_code == `OVF_RSP_OFS)
        nxt_q.rsp = cmd_wdata[7:0];
    end

    // Register reads answer one cycle later; unknown codes read zero
    if (cmd_rd)
    begin
      nxt_q.rd_ack = 1'b1;
      if (cmd_code == `OVF_THR_OFS)
        nxt_q.rd_data = q_ff.thr;
      else if (cmd_code == `OVF_RSP_OFS)
        nxt_q.rd_data = {8'h00, q_ff.rsp};
      else
        nxt_q.rd_data = `RD_UNMAPPED;
    end

    case (q_ff.state)
      // Normal operation
      ovf_pkg::ST_RUN:
      begin
        if (fault && !stop_retry)
        begin
          case (mode)
            // Keep running untouched
            `MODE_IGNORE: nxt_q.state = ovf_pkg::ST_RUN;
            // Keep running for the delay first
            `MODE_CONTINUE:
            begin
              nxt_q.state = ovf_pkg::ST_HOLD;
              load = 1'b1;
            end
            // Shut down now and follow the retry setting
            `MODE_RETRY:
            begin
              if (retry == `RETRY_NONE)
                nxt_q.state = ovf_pkg::ST_LATCH;
              else
              begin
                nxt_q.state = ovf_pkg::ST_WAIT;
                nxt_q.left = retry;
                load = 1'b1;
              end
            end
            default: nxt_q.state = ovf_pkg::ST_LATCH;
          endcase
        end
      end
      // Running on while the continue delay counts
      ovf_pkg::ST_HOLD:
      begin
        if (stop_retry)
          nxt_q.state = ovf_pkg::ST_RUN;
        else if (dl.expired)
        begin
          // Fault gone by the end of the delay: nothing to do
          if (!fault)
            nxt_q.state = ovf_pkg::ST_RUN;
          else if (retry == `RETRY_NONE)
            nxt_q.state = ovf_pkg::ST_LATCH;
          else
          begin
            nxt_q.state = ovf_pkg::ST_WAIT;
            nxt_q.left = retry;
            load = 1'b1;
          end
        end
      end
      // Output off, waiting for the next restart slot
      ovf_pkg::ST_WAIT:
      begin
        if (stop_retry)
          nxt_q.state = ovf_pkg::ST_RUN;
        else if (dl.expired)
        begin
          if (q_ff.left == 3'h0)
            nxt_q.state = ovf_pkg::ST_LATCH;
          else
          begin
            // Timer restarts at the attempt: spacing is start to start
            nxt_q.state = ovf_pkg::ST_TRY;
            load = 1'b1;
            if (retry != `RETRY_ENDLESS)
              nxt_q.left = q_ff.left - 3'h1;
          end
        end
      end
      // Restart attempt in progress
      ovf_pkg::ST_TRY:
      begin
        if (stop_retry)
          nxt_q.state = ovf_pkg::ST_RUN;
        else if (fault)
        begin
          // Failed attempt keeps the running spacing; a fault on the
          // expiry cycle would lose it, so a fresh delay starts then
          nxt_q.state = ovf_pkg::ST_WAIT;
          load = dl.expired;
        end
        else if (dl.expired)
          nxt_q.state = ovf_pkg::ST_RUN;
      end
      // Off until a clearing event
      ovf_pkg::ST_LATCH:
      begin
        if (clr_evt)
          nxt_q.state = ovf_pkg::ST_RUN;
      end
      default: nxt_q.state = ovf_pkg::ST_RUN;
    endcase

    // Output on only in running states and while commanded on
    nxt_q.out_en = on_cmd & ~other_fault &
      (nxt_q.state inside {ovf_pkg::ST_RUN, ovf_pkg::ST_HOLD,
      ovf_pkg::ST_TRY});
  end

  // State register; reset also clears a latched fault
  always_ff @(posedge clk)
  begin
    if (!resetn)
      q_ff <= CTL_RST;
    else
      q_ff <= nxt_q;
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign rd_data_ff = q_ff.rd_data;
  assign rd_ack_ff = q_ff.rd_ack;
  assign out_enable_ff = q_ff.out_en;
  assign ov_fault_flag_ff = q_ff.flag;

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_thr_write_held: assert property (
    cmd_wr && cmd_code == `OVF_THR_OFS |=> q_ff.thr == $past(cmd_wdata))
    else $error("limit write not stored");

  a_ignore_keeps_on: assert property (
    q_ff.state == ovf_pkg::ST_RUN && mode == `MODE_IGNORE && on_cmd &&
    !other_fault |=> out_enable_ff)
    else $error("ignore mode interrupted output");

  a_hold_keeps_on: assert property (
    q_ff.state == ovf_pkg::ST_HOLD && !dl.expired && !stop_retry
    |=> out_enable_ff && q_ff.state == ovf_pkg::ST_HOLD)
    else $error("continue delay did not keep output on");

  a_shutdown_now: assert property (
    q_ff.state == ovf_pkg::ST_RUN && fault && !stop_retry && mode[1]
    |=> !out_enable_ff)
    else $error("output not disabled on fault");

  a_latch_holds: assert property (
    q_ff.state == ovf_pkg::ST_LATCH && !clr_evt
    |=> q_ff.state == ovf_pkg::ST_LATCH && !out_enable_ff)
    else $error("latched fault released without clear");

  a_clear_exits: assert property (
    q_ff.state == ovf_pkg::ST_LATCH && clr_evt
    |=> q_ff.state == ovf_pkg::ST_RUN)
    else $error("clearing event did not release latch");

  a_no_retry_latch: assert property (
    q_ff.state == ovf_pkg::ST_RUN && fault && !stop_retry &&
    mode == `MODE_RETRY && retry == `RETRY_NONE
    |=> q_ff.state == ovf_pkg::ST_LATCH)
    else $error("zero retry setting attempted restart");

  a_retries_spent: assert property (
    q_ff.state == ovf_pkg::ST_WAIT && dl.expired && !stop_retry &&
    q_ff.left == 3'h0 |=> q_ff.state == ovf_pkg::ST_LATCH)
    else $error("restart after retries spent");

  a_endless_retry: assert property (
    q_ff.state == ovf_pkg::ST_WAIT && dl.expired && !stop_retry &&
    retry == `RETRY_ENDLESS |=> q_ff.state == ovf_pkg::ST_TRY)
    else $error("continuous retry stopped");

  a_off_stops: assert property (
    q_ff.state inside {ovf_pkg::ST_WAIT, ovf_pkg::ST_TRY} && stop_retry
    |=> q_ff.state == ovf_pkg::ST_RUN)
    else $error("retrying continued while commanded off");

  a_attempt_reload: assert property (
    q_ff.state == ovf_pkg::ST_WAIT && dl.expired && !stop_retry &&
    q_ff.left != 3'h0 |-> load ##1 out_enable_ff &&
    q_ff.state == ovf_pkg::ST_TRY)
    else $error("attempt did not restart spacing timer");

  a_flag_sticky: assert property (
    fault ##1 !clr_evt |-> ov_fault_flag_ff ##1 ov_fault_flag_ff)
    else $error("fault flag not sticky");

endmodule

/* tb/mgmt_host.sv */
// Host controller model: register commands and fault clearing strobes
module mgmt_host
(
  // Clock
  input wire logic clk,
  // Register command port
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data_ff,
  input wire logic rd_ack_ff,
  // Fault clearing
  output logic clear_faults,
  output logic status_clear
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial
  begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    clear_faults = 1'b0;
    status_clear = 1'b0;
  end

  // One-cycle write; released lines show inverted junk, not the old value
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmd_wr <= 1'b1;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_wr <= 1'b0;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
  endtask

  // One-cycle read, then a bounded wait for the acknowledge pulse
  task automatic rd(input logic [7:0] code, output logic [15:0] data,
                    output logic ok);
    int i;
    @(posedge clk);
    cmd_rd <= 1'b1;
    cmd_code <= code;
    @(posedge clk);
    cmd_rd <= 1'b0;
    cmd_code <= ~code;
    ok = 1'b0;
    data = 16'hdead;
    for (i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (rd_ack_ff === 1'b1)
      begin
        ok = 1'b1;
        data = rd_data_ff;
      end
      else
        @(posedge clk);
    end
  endtask

  // Clear pulse: all faults when which is high, status bit otherwise
  task automatic clr(input logic which);
    @(posedge clk);
    clear_faults <= which;
    status_clear <= !which;
    @(posedge clk);
    clear_faults <= 1'b0;
    status_clear <= 1'b0;
  endtask
endmodule

/* tb/tb.sv */
// Self-checking testbench of the input over-voltage fault responder
`include "ovf_regs.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // Levels, counters and wires
  // ------------------------------------------------------------------
  localparam logic [15:0] lim_v = 16'h0100; // Limit, exponent zero
  localparam logic [15:0] hi_v = 16'h0180; // Above the limit
  localparam logic [15:0] lo_v = 16'h0080; // Below the limit
  localparam logic [15:0] unit_v = 16'h0002; // Kept short for run time
  int errors = 0;
  int n_tests = 0;
  logic clk, resetn, cmd_wr, cmd_rd, rd_ack_ff, clear_faults, status_clear;
  logic on_cmd, other_fault, out_enable_ff, ov_fault_flag_ff;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data_ff, vin_meas, delay_unit;

  ovf_fault_responder u_ovf_fault_responder (.clk(clk), .resetn(resetn),
    .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_data_ff(rd_data_ff), .rd_ack_ff(rd_ack_ff),
    .clear_faults(clear_faults), .status_clear(status_clear),
    .vin_meas(vin_meas), .on_cmd(on_cmd), .other_fault(other_fault),
    .delay_unit(delay_unit), .out_enable_ff(out_enable_ff),
    .ov_fault_flag_ff(ov_fault_flag_ff));

  mgmt_host u_mgmt_host (.clk(clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_ff(rd_data_ff),
    .rd_ack_ff(rd_ack_ff), .clear_faults(clear_faults),
    .status_clear(status_clear));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ------------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Step n edges, then let their updates land before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fault(input logic on);
    @(posedge clk);
    vin_meas <= on ? hi_v : lo_v;
    #1;
  endtask

  // Cycles the output stays at lvl, bounded so a stuck design cannot hang
  task automatic run_len(input logic lvl, output int len);
    len = 0;
    while (len < 300 && out_enable_ff === lvl)
    begin
      tick(1);
      len++;
    end
  endtask

  task automatic watch(input int span, output int rises, output int lows);
    logic prev;
    prev = out_enable_ff;
    rises = 0;
    lows = 0;
    repeat (span)
    begin
      tick(1);
      rises += (out_enable_ff === 1'b1 && prev === 1'b0);
      lows += (out_enable_ff !== 1'b1);
      prev = out_enable_ff;
    end
  endtask

  // Program limit and reaction; an off-on of the output command stops
  // retrying left from the last scenario, since a clear alone does not
  task automatic setup(input logic [7:0] rsp);
    int i;
    @(posedge clk);
    on_cmd <= 1'b0;
    vin_meas <= lo_v;
    u_mgmt_host.wr(`OVF_THR_OFS, lim_v);
    u_mgmt_host.wr(`OVF_RSP_OFS, {8'h00, rsp});
    @(posedge clk);
    on_cmd <= 1'b1;
    u_mgmt_host.clr(1'b1);
    tick(2);
    for (i = 0; i < 20 && out_enable_ff !== 1'b1; i++)
      tick(1);
    chk("output ready", 1, out_enable_ff);
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_regs;
    logic [15:0] d;
    logic ok;
    u_mgmt_host.rd(`OVF_THR_OFS, d, ok);
    chk("limit reset", `THR_RST, d);
    u_mgmt_host.rd(`OVF_RSP_OFS, d, ok);
    chk("reaction reset", {8'h00, `RSP_RST}, d);
    u_mgmt_host.rd(8'h57, d, ok);
    chk("unmapped read", `RD_UNMAPPED, d);
    chk("read ack", 1, ok);
    u_mgmt_host.wr(`OVF_THR_OFS, 16'h1234);
    u_mgmt_host.wr(`OVF_RSP_OFS, 16'ha55a);
    u_mgmt_host.rd(`OVF_THR_OFS, d, ok);
    chk("limit rw", 16'h1234, d);
    u_mgmt_host.rd(`OVF_RSP_OFS, d, ok);
    chk("reaction rw", 16'h005a, d);
  endtask

  // Ignore mode: output untouched, flag sticky until cleared
  task automatic t_ignore;
    int r, lo;
    setup(8'h00);
    fault(1'b1);
    watch(30, r, lo);
    chk("ignore lows", 0, lo);
    chk("flag set", 1, ov_fault_flag_ff);
    u_mgmt_host.clr(1'b0);
    tick(2);
    chk("flag with fault", 1, ov_fault_flag_ff);
    fault(1'b0);
    u_mgmt_host.clr(1'b0);
    tick(2);
    chk("flag cleared", 0, ov_fault_flag_ff);
  endtask

  // Continue mode: short fault rides through, long one ends the run
  task automatic t_continue;
    int r, lo, len;
    setup(8'h43);
    fault(1'b1);
    tick(4);
    fault(1'b0);
    watch(40, r, lo);
    chk("short fault lows", 0, lo);
    fault(1'b1);
    run_len(1'b1, len);
    chk("hold window", 1, len >= 16 && len <= 22);
    watch(30, r, lo);
    chk("after hold", 0, out_enable_ff);
    // Fault outlasting the delay hands over to one retry
    setup(8'h48);
    fault(1'b1);
    watch(30, r, lo);
    chk("hold then retry", 1, r);
    chk("hold retry lows", 1, lo > 20);
    fault(1'b0);
  endtask

  // Restart spacing for every multiplier code, start to start
  task automatic t_mult;
    int k, l1, l2, h, l0, s;
    for (k = 0; k < 8; k++)
    begin
      setup({2'b10, 3'b010, 3'(k)});
      fault(1'b1);
      run_len(1'b1, h);
      run_len(1'b0, l1);
      run_len(1'b1, h);
      run_len(1'b0, l2);
      if (k == 0)
        l0 = l2;
      s = (1 << k) * unit_v;
      chk("spacing step", l0 + s - unit_v, l2);
      chk("spacing window", 1, l2 + 1 >= s && l2 + 1 <= s + 2);
      fault(1'b0);
    end
    // Another unit length must scale the spacing with it
    @(posedge clk);
    delay_unit <= 16'h0005;
    setup(8'h91);
    fault(1'b1);
    run_len(1'b1, h);
    run_len(1'b0, l1);
    run_len(1'b1, h);
    run_len(1'b0, l2);
    chk("unit spacing", 10, l2);
    fault(1'b0);
    @(posedge clk);
    delay_unit <= unit_v;
  endtask

  // Retry codes 0 to 6: that many attempts, then off for good
  task automatic t_retry;
    int n, r, lo;
    for (n = 0; n < 7; n++)
    begin
      setup({2'b10, 3'(n), 3'b000});
      fault(1'b1);
      watch(60, r, lo);
      chk("attempts", n, r);
      chk("final off", 0, out_enable_ff);
      fault(1'b0);
    end
  endtask

  // Endless retries stop once the output is commanded off
  task automatic t_endless;
    int r, lo;
    setup({2'b10, `RETRY_ENDLESS, 3'b000});
    fault(1'b1);
    watch(80, r, lo);
    chk("endless attempts", 1, r > 6);
    @(posedge clk);
    on_cmd <= 1'b0;
    tick(3);
    watch(40, r, lo);
    chk("stopped attempts", 0, r);
    chk("stopped off", 0, out_enable_ff);
    @(posedge clk);
    on_cmd <= 1'b1;
    watch(20, r, lo);
    chk("resumed attempts", 1, r > 3);
    // Another shutdown cause must stop the retrying as well
    @(posedge clk);
    other_fault <= 1'b1;
    tick(3);
    watch(40, r, lo);
    chk("fault stop attempts", 0, r);
    chk("fault stop off", 0, out_enable_ff);
    fault(1'b0);
    @(posedge clk);
    other_fault <= 1'b0;
  endtask

  // Latch mode released by each clearing event in turn
  task automatic t_latch;
    int m;
    for (m = 0; m < 4; m++)
    begin
      setup(8'hc0);
      fault(1'b1);
      tick(3);
      chk("latch off", 0, out_enable_ff);
      fault(1'b0);
      tick(20);
      chk("latch holds", 0, out_enable_ff);
      case (m)
        0: u_mgmt_host.clr(1'b0);
        1: u_mgmt_host.clr(1'b1);
        2:
        begin
          @(posedge clk);
          on_cmd <= 1'b0;
          tick(3);
          @(posedge clk);
          on_cmd <= 1'b1;
        end
        default:
        begin
          @(posedge clk);
          resetn <= 1'b0;
          repeat (2) @(posedge clk);
          resetn <= 1'b1;
        end
      endcase
      tick(4);
      chk("released on", 1, out_enable_ff);
      chk("released flag", 0, ov_fault_flag_ff);
    end
  endtask

  // ------------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Reset held two cycles, then every scenario in turn
  initial
  begin
    resetn = 1'b0;
    vin_meas = lo_v;
    on_cmd = 1'b1;
    other_fault = 1'b0;
    delay_unit = unit_v;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs;
    t_ignore;
    t_continue;
    t_mult;
    t_retry;
    t_endless;
    t_latch;
    tally_and_finish;
  end

  // Scenarios need a few thousand cycles; 60000 means a hang
  initial
  begin
    #6000000;
    errors++;
    $display("BAD watchdog expected done seen running");
    tally_and_finish;
  end
endmodule
